// file: src/fsirq_ctrl.sv
// Fast, software and spurious interrupt logic of the vectored controller.
// Assumes software drives the Avalon-MM port and the core samples the
// active-low request lines.
`timescale 1ns/1ps

module fsirq_ctrl
  import fsirq_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt source pins
  input wire logic fast_pin,
  input wire logic [5:0] src_pin,
  // Requests to the core
  output logic irq_req_n,
  output logic fast_req_n,
  // Event interrupt
  output logic evt_irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  fsirq_state_t state_r;
  fsirq_mode_t mode_r [0:NSRC-1];
  fsirq_vsel_t vsel_r;
  logic [8:0] rd_addr_r;
  logic [31:0] rdata_r;
  logic [31:0] spu_r;
  logic [7:0] mask_r;
  logic [7:0] pend;
  logic [7:0] pend_e_r;
  logic [7:0] ack_clr;
  logic [7:0] raw;
  logic [7:0] s1_r, s2_r, s3_r, filt_r, filt_d_r;
  logic [2:0] stk_r [0:STK_DEPTH-1];
  logic [3:0] depth_r;
  logic [2:0] cur_lvl;
  logic [2:0] cur_src_r;
  logic spur_hold_r;
  logic [2:0] evt_r, evm_r, evt_set;
  logic cand_valid;
  logic [2:0] cand_src, cand_prio;
  logic fast_act;
  logic rd_take, ivr_rd, fvr_rd, irq_ack, fast_ack, spur_enter;
  logic wr_ok, eoi_wr;
  logic [31:0] mem_q;
  logic [2:0] mem_rd_idx;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Source 1 has no pin; its raw level is a constant low.
  assign raw = {src_pin, 1'b0, fast_pin};

  // Three stages; the filtered level moves only when stages two and
  // three agree, which rejects a single-cycle glitch on the pin.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= 8'h00;
      s2_r <= 8'h00;
      s3_r <= 8'h00;
      filt_r <= 8'h00;
      filt_d_r <= 8'h00;
    end
    else
    begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
      filt_d_r <= filt_r;
    end
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Partial-word writes are ignored; every register is a full word.
  assign wr_ok = avs_write && (avs_byteenable == 4'hf);
  assign eoi_wr = wr_ok && (avs_address[8:2] == OFF_EOI[8:2]);

  // A read is acted on once, in the cycle the idle machine takes it.
  assign rd_take = avs_read && (state_r == ST_IDLE);
  assign ivr_rd = rd_take && (avs_address[8:2] == OFF_IVR[8:2]);
  assign fvr_rd = rd_take && (avs_address[8:2] == OFF_FVR[8:2]);

  // Vector reads are decided from the live candidate, so a request that
  // vanished or was disabled before the read ends up spurious.
  assign irq_ack = ivr_rd && cand_valid;
  assign fast_ack = fvr_rd && fast_act;
  assign spur_enter = (ivr_rd && !cand_valid) ||
                      (fvr_rd && !fast_act);

  // ----------------------------------------------------------------
  // Per-source pending state
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi = gi + 1)
    begin : g_src
      logic is_edge, hi_act, edge_hit, set_hit, clr_hit;
      // Source 1 is internal: its active sense is always high.
      assign is_edge = mode_r[gi].srctype[0];
      assign hi_act = (gi == SW_SRC) ? 1'b1 : mode_r[gi].srctype[1];
      // Rising or falling edge, or high or low level, per mode.
      assign edge_hit = hi_act ? (filt_r[gi] && !filt_d_r[gi]) :
                                 (!filt_r[gi] && filt_d_r[gi]);
      // Commands reach only edge-mode sources.
      assign set_hit = wr_ok && is_edge && avs_writedata[gi] &&
                       (avs_address[8:2] == OFF_SET[8:2]);
      assign clr_hit = (wr_ok && is_edge && avs_writedata[gi] &&
                        (avs_address[8:2] == OFF_CLR[8:2])) ||
                       ack_clr[gi];

      // A new edge or set in the same cycle as a clear wins.
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pend_e_r[gi] <= 1'b0;
        end
        else if (!is_edge)
        begin
          pend_e_r[gi] <= 1'b0;
        end
        else if (edge_hit || set_hit)
        begin
          pend_e_r[gi] <= 1'b1;
        end
        else if (clr_hit)
        begin
          pend_e_r[gi] <= 1'b0;
        end
      end

      // Level sources follow the synchronised pin directly.
      assign pend[gi] = is_edge ? pend_e_r[gi] :
                        (filt_r[gi] == hi_act);
      assign ack_clr[gi] = (irq_ack && (cand_src == gi)) ||
                           (fast_ack && (gi == FAST_SRC));
    end
  endgenerate

  // ----------------------------------------------------------------
  // Priority encoder for the normal request
  // ----------------------------------------------------------------
  assign cur_lvl = (depth_r == 4'd0) ? 3'd0 : stk_r[depth_r[2:0] - 3'd1];

  // Source 0 is left out: the fast path never competes for priority.
  // Strict comparison keeps the lowest source number on a tie.
  always_comb
  begin
    cand_valid = 1'b0;
    cand_src = 3'd0;
    cand_prio = 3'd0;
    for (int i = 1; i < NSRC; i++)
    begin
      if (pend[i] && mask_r[i] &&
          ((depth_r == 4'd0) || (mode_r[i].prio > cur_lvl)) &&
          (!cand_valid || (mode_r[i].prio > cand_prio)))
      begin
        cand_valid = 1'b1;
        cand_src = i[2:0];
        cand_prio = mode_r[i].prio;
      end
    end
  end

  // ----------------------------------------------------------------
  // Request lines
  // ----------------------------------------------------------------
  assign fast_act = pend[FAST_SRC] && mask_r[FAST_SRC];

  always_comb
  begin
    irq_req_n = !(cand_valid && !spur_hold_r);
    fast_req_n = !(fast_act && !spur_hold_r);
  end

  // ----------------------------------------------------------------
  // Priority stack and current source
  // ----------------------------------------------------------------
  // An acknowledged IRQ pushes its level; end-of-interrupt pops it.
  // A full stack stops pushing, so deeper nesting is not tracked.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      depth_r <= 4'd0;
      cur_src_r <= 3'd0;
      for (int i = 0; i < STK_DEPTH; i++)
      begin
        stk_r[i] <= 3'd0;
      end
    end
    else if (irq_ack)
    begin
      cur_src_r <= cand_src;
      if (depth_r != 4'(STK_DEPTH))
      begin
        stk_r[depth_r[2:0]] <= cand_prio;
        depth_r <= depth_r + 4'd1;
      end
    end
    else if (eoi_wr && !spur_hold_r && (depth_r != 4'd0))
    begin
      depth_r <= depth_r - 4'd1;
    end
  end

  // ----------------------------------------------------------------
  // Spurious hold
  // ----------------------------------------------------------------
  // The end write that releases the hold does not pop the stack, since
  // a spurious read never pushed. Entry wins over a same-cycle release.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      spur_hold_r <= 1'b0;
    end
    else if (spur_enter)
    begin
      spur_hold_r <= 1'b1;
    end
    else if (eoi_wr)
    begin
      spur_hold_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      spu_r <= RST_WORD;
      mask_r <= RST_MASK;
      evm_r <= RST_EVT;
      for (int i = 0; i < NSRC; i++)
      begin
        mode_r[i] <= '0;
      end
    end
    else if (wr_ok)
    begin
      if (avs_address[8:5] == OFF_MODE[8:5])
      begin
        mode_r[avs_address[4:2]].srctype <=
          avs_writedata[MODE_TYPE_LSB +: 2];
        mode_r[avs_address[4:2]].prio <= avs_writedata[MODE_PRIO_LSB +: 3];
      end
      case (avs_address[8:2])
        OFF_SPU[8:2]: spu_r <= avs_writedata;
        OFF_EN[8:2]: mask_r <= mask_r | avs_writedata[7:0];
        OFF_DIS[8:2]: mask_r <= mask_r & ~avs_writedata[7:0];
        OFF_EVM[8:2]: evm_r <= avs_writedata[2:0];
        default: mask_r <= mask_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Event status
  // ----------------------------------------------------------------
  assign evt_set = {fast_ack, irq_ack, spur_enter};

  // Write one to clear; an event in the clearing cycle stays set.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      evt_r <= RST_EVT;
    end
    else if (wr_ok && (avs_address[8:2] == OFF_EVT[8:2]))
    begin
      evt_r <= (evt_r & ~avs_writedata[2:0]) | evt_set;
    end
    else
    begin
      evt_r <= evt_r | evt_set;
    end
  end

  assign evt_irq = |(evt_r & evm_r);

  // ----------------------------------------------------------------
  // Vector memory
  // ----------------------------------------------------------------
  always_comb
  begin
    if (ivr_rd)
    begin
      mem_rd_idx = cand_src;
    end
    else if (fvr_rd)
    begin
      mem_rd_idx = 3'(FAST_SRC);
    end
    else
    begin
      mem_rd_idx = avs_address[4:2];
    end
  end

  fsirq_vec_mem u_vec_mem (
    .core_clk(core_clk),
    .wr_en(wr_ok && (avs_address[8:5] == OFF_VEC[8:5])),
    .wr_idx(avs_address[4:2]),
    .wr_data(avs_writedata),
    .rd_idx(mem_rd_idx),
    .rd_data(mem_q)
  );

  // ----------------------------------------------------------------
  // Read machine
  // ----------------------------------------------------------------
  // Reads take three edges: decide, fetch from memory, answer. Writes
  // finish at the first edge with no wait.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      vsel_r <= '0;
      rd_addr_r <= 9'h000;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (avs_read)
          begin
            state_r <= ST_WAIT;
            rd_addr_r <= avs_address;
            vsel_r.spur <= spur_enter;
            vsel_r.src <= mem_rd_idx;
          end
        end
        ST_WAIT: state_r <= ST_DONE;
        ST_DONE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Read data; unmapped and write-only offsets read as zero.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_r <= RST_WORD;
    end
    else if (state_r == ST_WAIT)
    begin
      if (rd_addr_r[8:5] == OFF_MODE[8:5])
      begin
        rdata_r <= {25'h0, mode_r[rd_addr_r[4:2]].srctype, 2'h0,
                    mode_r[rd_addr_r[4:2]].prio};
      end
      else if (rd_addr_r[8:5] == OFF_VEC[8:5])
      begin
        rdata_r <= mem_q;
      end
      else
      begin
        case (rd_addr_r[8:2])
          OFF_IVR[8:2], OFF_FVR[8:2]:
            rdata_r <= vsel_r.spur ? spu_r : mem_q;
          OFF_STAT[8:2]: rdata_r <= {29'h0, cur_src_r};
          OFF_PEND[8:2]: rdata_r <= {24'h0, pend};
          OFF_MASK[8:2]: rdata_r <= {24'h0, mask_r};
          OFF_CORE[8:2]: rdata_r <= {30'h0, !fast_req_n, !irq_req_n};
          OFF_SPU[8:2]: rdata_r <= spu_r;
          OFF_EVT[8:2]: rdata_r <= {29'h0, evt_r};
          OFF_EVM[8:2]: rdata_r <= {29'h0, evm_r};
          default: rdata_r <= RST_WORD;
        endcase
      end
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = avs_read ? (state_r != ST_DONE) : 1'b0;

endmodule

// file: src/fsirq_pkg.sv
// Constants, types and register offsets for the fast, software and
// spurious interrupt logic of the vectored interrupt controller.
// Assumes one core clock and a byte-addressed Avalon-MM register port.
//
// Behaviour
// - Edge sources, fast included, go pending on set, stop on clear.
// - Only source 0, from its pin or a software set, drives the fast request line.
// - The fast path skips the priority encoder; its priority is unused.
// - Source 0 mode picks rising, falling, high or low sensitivity.
// - Fast vector read returns what software stored in source 0 vector.
// - Source 1 is a software interrupt, set and cleared when edge mode.
// - Request gone before the vector read gives the spurious vector.
// - The spurious vector is a software-writable setting.
// - A level source dropping as the core samples gives spurious.
// - A source disabled as it asserts gives a spurious vector read.
// - Vector reads with nothing pending return spurious, IRQ and fast.
// - In spurious handling both request lines stay off until end write.
// - IRQ vector read returns best source, drops line, clears edge.
// - End-of-interrupt write restores the last stacked priority level.

package fsirq_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NSRC = 8;
  localparam int FAST_SRC = 0;
  localparam int SW_SRC = 1;
  localparam int STK_DEPTH = 8;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [8:0] OFF_MODE = 9'h000;
  localparam logic [8:0] OFF_VEC = 9'h080;
  localparam logic [8:0] OFF_IVR = 9'h100;
  localparam logic [8:0] OFF_FVR = 9'h104;
  localparam logic [8:0] OFF_STAT = 9'h108;
  localparam logic [8:0] OFF_PEND = 9'h10c;
  localparam logic [8:0] OFF_MASK = 9'h110;
  localparam logic [8:0] OFF_CORE = 9'h114;
  localparam logic [8:0] OFF_EN = 9'h120;
  localparam logic [8:0] OFF_DIS = 9'h124;
  localparam logic [8:0] OFF_CLR = 9'h128;
  localparam logic [8:0] OFF_SET = 9'h12c;
  localparam logic [8:0] OFF_EOI = 9'h130;
  localparam logic [8:0] OFF_SPU = 9'h134;
  localparam logic [8:0] OFF_EVT = 9'h140;
  localparam logic [8:0] OFF_EVM = 9'h144;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int MODE_PRIO_LSB = 0;
  localparam int MODE_TYPE_LSB = 5;
  localparam int EVT_SPUR = 0;
  localparam int EVT_IRQ_ACK = 1;
  localparam int EVT_FAST_ACK = 2;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [2:0] RST_EVT = 3'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Source mode: type bit 1 is high/rising, type bit 0 is edge.
  typedef struct packed {
    logic [1:0] srctype;
    logic [2:0] prio;
  } fsirq_mode_t;

  // Vector selection latched when a vector register is read.
  typedef struct packed {
    logic spur;
    logic [2:0] src;
  } fsirq_vsel_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_DONE
  } fsirq_state_t;

endpackage

// file: src/fsirq_vec_mem.sv
// Source vector store: one 32-bit handler address per source.
// Assumes the caller presents the read address one cycle before it wants data.
`timescale 1ns/1ps

module fsirq_vec_mem
  import fsirq_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Write side
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [31:0] wr_data,
  // Read side
  input wire logic [2:0] rd_idx,
  output logic [31:0] rd_data
);

  logic [31:0] mem [0:NSRC-1];

  // Synchronous write and registered read; no reset so it maps to RAM.
  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= mem[rd_idx];
  end

endmodule

// file: testbench/fsirq_ctrl_monitor.sv
// Checker for the fast, software and spurious interrupt logic.
// Assumes it sees only the controller ports and aligned full-word writes.
`timescale 1ns/1ps

module fsirq_ctrl_monitor
  import fsirq_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Pins and request lines
  input wire logic fast_pin,
  input wire logic [5:0] src_pin,
  input wire logic irq_req_n,
  input wire logic fast_req_n,
  input wire logic evt_irq
);
  // ----------------------------------------------------------------
  // Shadow state
  // ----------------------------------------------------------------
  logic [31:0] spu_r;
  logic [31:0] vec0_r;
  logic evm0_r;
  logic hold_r;
  logic wr_ok;
  logic rd_done;

  // A vector read completes on 0x100 or 0x104 only.
  assign wr_ok = avs_write && (avs_byteenable == 4'hf);
  assign rd_done = avs_read && !avs_waitrequest &&
    (avs_address[8:3] == OFF_IVR[8:3]);

  // Copies of the software settings that the checks compare against.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      spu_r <= 32'h0000_0000;
      vec0_r <= 32'h0000_0000;
      evm0_r <= 1'b0;
    end
    else if (wr_ok)
    begin
      case (avs_address)
        OFF_SPU: spu_r <= avs_writedata;
        OFF_VEC: vec0_r <= avs_writedata;
        OFF_EVM: evm0_r <= avs_writedata[0];
        default: ;
      endcase
    end
  end

  // The hold is inferred from the vector returned, so tests must keep
  // every handler address distinct from the spurious vector.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      hold_r <= 1'b0;
    else if (wr_ok && avs_address == OFF_EOI)
      hold_r <= 1'b0;
    else if (rd_done && avs_readdata == spu_r)
      hold_r <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  property p_rd_lat;
    $rose(avs_read) |-> avs_waitrequest [*2] ##1 !avs_waitrequest;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read timing");

  property p_wr_now;
    avs_write |-> !avs_waitrequest;
  endproperty
  a_wr_now: assert property (p_wr_now) else $error("write waited");

  property p_hold;
    hold_r |-> irq_req_n && fast_req_n;
  endproperty
  a_hold: assert property (p_hold) else $error("line during hold");

  property p_ivr_spu;
    $rose(avs_read) && avs_address == OFF_IVR && irq_req_n && !hold_r
      |-> ##2 avs_readdata == spu_r;
  endproperty
  a_ivr_spu: assert property (p_ivr_spu) else $error("spurious");

  property p_fvr_spu;
    $rose(avs_read) && avs_address == OFF_FVR && fast_req_n && !hold_r
      |-> ##2 avs_readdata == spu_r;
  endproperty
  a_fvr_spu: assert property (p_fvr_spu) else $error("spurious");

  property p_fvr_vec;
    $rose(avs_read) && avs_address == OFF_FVR && !fast_req_n
      |-> ##2 avs_readdata == vec0_r;
  endproperty
  a_fvr_vec: assert property (p_fvr_vec) else $error("fast vec");

  property p_ivr_ack;
    $rose(avs_read) && avs_address == OFF_IVR && !irq_req_n
      |-> ##1 irq_req_n ##1 avs_readdata != spu_r;
  endproperty
  a_ivr_ack: assert property (p_ivr_ack) else $error("irq ack");

  property p_evt;
    $rose(hold_r) && evm0_r |-> evt_irq;
  endproperty
  a_evt: assert property (p_evt) else $error("event missing");
endmodule

bind fsirq_ctrl fsirq_ctrl_monitor i_mon (
  .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .fast_pin(fast_pin), .src_pin(src_pin), .irq_req_n(irq_req_n),
  .fast_req_n(fast_req_n), .evt_irq(evt_irq)
);

// file: testbench/fsirq_core_model.sv
// Behavioural processor core watching the two request lines.
// Assumes active-low lines sampled on the core clock.
`timescale 1ns/1ps

module fsirq_core_model
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Request lines
  input wire logic irq_req_n,
  input wire logic fast_req_n,
  // Exception entry taken
  output logic irq_taken,
  output logic fast_taken,
  output logic [31:0] entry_addr
);
  // The core registers the lines, so it reacts one edge late.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_taken <= 1'b0;
      fast_taken <= 1'b0;
    end
    else
    begin
      irq_taken <= !irq_req_n;
      fast_taken <= !fast_req_n;
    end
  end

  // The fast entry holds a PC load from the fast vector read.
  assign entry_addr = fast_taken ? 32'h0000_001c : 32'h0000_0018;
endmodule

// file: testbench/fsirq_ctrl_test.sv
// Self-checking bench for the fast, software and spurious interrupt logic.
// Assumes the controller and the core model; every wait is bounded.
`timescale 1ns/1ps

module fsirq_ctrl_test
  import fsirq_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [31:0] SPU = 32'h5a5a_0001;
  localparam logic [31:0] V0 = 32'h0000_f000;
  localparam logic [31:0] V1 = 32'h0000_f100;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [8:0] avs_address = 9'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic fast_pin = 1'b1;
  logic [5:0] src_pin = 6'h3f;
  logic irq_req_n;
  logic fast_req_n;
  logic evt_irq;
  logic irq_taken;
  logic fast_taken;
  logic [31:0] rd;
  int fail_count = 0;
  int n_checks = 0;
  int t;

  // 125 MHz core clock.
  always #4 core_clk = ~core_clk;

  fsirq_ctrl i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .fast_pin(fast_pin),
    .src_pin(src_pin), .irq_req_n(irq_req_n), .fast_req_n(fast_req_n),
    .evt_irq(evt_irq));

  fsirq_core_model i_core (.core_clk(core_clk), .rst_n(rst_n),
    .irq_req_n(irq_req_n), .fast_req_n(fast_req_n),
    .irq_taken(irq_taken), .fast_taken(fast_taken), .entry_addr());

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task tmo;
    fail_count++;
    end_sim();
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waitrequest and read data are taken at the rising edge itself, and
  // the request is released by non-blocking assignment at that edge.
  task bus(input logic w, input logic [8:0] a, input logic [31:0] d,
           output logic [31:0] q);
    int i;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    for (i = 0; i < 50; i++)
    begin
      @(posedge core_clk);
      if (!avs_waitrequest)
        break;
    end
    if (i == 50)
      tmo();
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task wr(input logic [8:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask

  task rdchk(input logic [8:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, rd);
    chk(rd, exp);
  endtask

  task wait_req(input logic fast);
    int i;
    for (i = 0; i < 40; i++)
    begin
      @(negedge core_clk);
      if (fast ? fast_taken : irq_taken)
        break;
    end
    if (i == 40)
      tmo();
  endtask

  task idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task lines(input logic [1:0] exp);
    @(negedge core_clk);
    chk({30'h0, fast_req_n, irq_req_n}, {30'h0, exp});
  endtask

  task evchk(input logic exp);
    @(negedge core_clk);
    chk({31'h0, evt_irq}, {31'h0, exp});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    wr(OFF_SPU, SPU);
    // A partial-word write must leave the spurious vector alone.
    avs_byteenable <= 4'h3;
    wr(OFF_SPU, 32'h0000_0000);
    avs_byteenable <= 4'hf;
    wr(OFF_VEC, V0);
    wr(OFF_VEC + 9'h004, V1);
    wr(OFF_EVM, 32'h0000_0001);
    rdchk(OFF_SPU, SPU);
    rdchk(9'h020, 32'h0000_0000);
    // Nothing pending: spurious entry, event raised, masked and cleared.
    rdchk(OFF_IVR, SPU);
    lines(2'b11);
    evchk(1'b1);
    wr(OFF_EVM, 32'h0000_0000);
    evchk(1'b0);
    wr(OFF_EVM, 32'h0000_0001);
    wr(OFF_EVT, 32'h0000_0007);
    evchk(1'b0);
    wr(OFF_EOI, 32'h0000_0000);
    rdchk(OFF_FVR, SPU);
    wr(OFF_EOI, 32'h0000_0000);
    // Software source set, cleared, acknowledged, held off at its own level, then level mode.
    wr(OFF_MODE + 9'h004, 32'h0000_0023);
    wr(OFF_EN, 32'h0000_0003);
    wr(OFF_SET, 32'h0000_0002);
    wait_req(1'b0);
    rdchk(OFF_PEND, 32'h0000_0002);
    wr(OFF_CLR, 32'h0000_0002);
    rdchk(OFF_PEND, 32'h0000_0000);
    wr(OFF_SET, 32'h0000_0002);
    wait_req(1'b0);
    rdchk(OFF_IVR, V1);
    rdchk(OFF_PEND, 32'h0000_0000);
    wr(OFF_SET, 32'h0000_0002);
    lines(2'b11);
    wr(OFF_EOI, 32'h0000_0000);
    wait_req(1'b0);
    rdchk(OFF_IVR, V1);
    wr(OFF_EOI, 32'h0000_0000);
    wr(OFF_MODE + 9'h004, 32'h0000_0003);
    wr(OFF_SET, 32'h0000_0002);
    rdchk(OFF_PEND, 32'h0000_0000);
    // Fast input in each of its four sensitivities.
    for (t = 0; t < 4; t++)
    begin
      @(posedge core_clk);
      fast_pin <= ~t[1];
      idle(6);
      wr(OFF_MODE, {25'h0, t[1:0], 5'h00});
      wr(OFF_CLR, 32'h0000_0001);
      fast_pin <= t[1];
      wait_req(1'b1);
      rdchk(OFF_FVR, V0);
      fast_pin <= ~t[1];
      idle(6);
      lines(2'b11);
    end
    // Level source dropping before the vector read, then a disable.
    // Source 2 idles low first so that its mode change raises nothing.
    @(posedge core_clk);
    src_pin <= 6'h3e;
    idle(6);
    wr(OFF_MODE + 9'h008, 32'h0000_0042);
    wr(OFF_EN, 32'h0000_0004);
    src_pin <= 6'h3f;
    wait_req(1'b0);
    @(posedge core_clk);
    src_pin <= 6'h3e;
    idle(6);
    rdchk(OFF_IVR, SPU);
    src_pin <= 6'h3f;
    idle(6);
    lines(2'b11);
    wr(OFF_EOI, 32'h0000_0000);
    wait_req(1'b0);
    wr(OFF_DIS, 32'h0000_0004);
    rdchk(OFF_IVR, SPU);
    lines(2'b11);
    wr(OFF_EOI, 32'h0000_0000);
    src_pin <= 6'h3e;
    end_sim();
  end
endmodule
